// ==== rtl/rtmsr_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtmsr_defs.svh"

// Summary of operation
// R1 - Read request: flags, 23h, UID, block, count, CRC.
// R2 - Count field is blocks minus one.
// R3 - First block numbers 00h to 1FFh accepted.
// R4 - At most 32 blocks, one sector only.
// R5 - Sector crossing gives an error response.
// R6 - Extension flag zero gives an error response.
// R7 - Read answer: flags, security, data, CRC. The code sends the security byte only when the option flag is set.
// R8 - Security byte top three bits zero.
// R9 - Read errors 0Fh, 10h or 15h.
// R10 - Busy mode: pin low during read.
// R11 - Write-progress mode: pin left floating.
// R12 - Select request: flags, 25h, UID, CRC.
// R13 - Matching select enters Selected, answers.
// R14 - Mismatching select drops to Ready, silent.
// R15 - Select errors only on match; keep state.
// R16 - Select and ready errors use 03h.
// R17 - Return-ready command moves to Ready.
// R18 - Addressed return-ready errors only on match.
// R19 - Select and ready answer flags, CRC only.
// R20 - Busy mode: pin low during select.
// R21 - Busy mode: pin low during return-ready.
// R22 - CRC added to answers; bad requests dropped.
module rtmsr_cmd (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	input wire rtmsr_pkg::rtmsr_rx_t rx,
	input wire logic tx_ready,
	output rtmsr_pkg::rtmsr_tx_t tx,
	output logic mem_rd,
	output logic [8:0] mem_addr,
	input wire rtmsr_pkg::rtmsr_mem_t mem_rsp,
	output logic rf_activity_pin_out,
	output logic rf_activity_pin_oe
);

	// ****************************************
	// State and decode
	// ****************************************
	rtmsr_pkg::rtmsr_state_t s_reg;
	rtmsr_pkg::rtmsr_state_t s_next;
	logic has_uid;
	logic [4:0] base;
	logic [4:0] exp_len;
	logic ext;
	logic opt;
	logic good;
	logic match;
	logic reach;
	logic is_read;
	logic [16:0] last_blk;

	// One CRC step over a byte, least significant bit first.
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ `RTMSR_CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc8

	// A UID follows the command when addressed, and always for select.
	assign has_uid = s_reg.flags[`RTMSR_FLG_ADDR] || (s_reg.cmd == `RTMSR_CMD_SEL); // R12
	assign base = has_uid ? 5'h0A : 5'h02;
	assign ext = s_reg.flags[`RTMSR_FLG_EXT];
	assign opt = s_reg.flags[`RTMSR_FLG_OPT];
	assign is_read = (s_reg.cmd == `RTMSR_CMD_READ);

	// Expected frame length: the block field is two bytes only with the extension flag.
	always_comb begin
		if (is_read) begin
			exp_len = base + (ext ? 5'h05 : 5'h04); // R1
		end else begin
			exp_len = base + 5'h02;
		end
	end

	// The running CRC over a clean frame, CRC bytes included, lands on the fixed residue.
	assign good = (s_reg.pos == exp_len) && (s_reg.rcrc == `RTMSR_CRC_RES); // R22
	assign match = (s_reg.uid == s_reg.own);
	assign reach = !(s_reg.flags[`RTMSR_FLG_ADDR] && !match)
		&& !(s_reg.flags[`RTMSR_FLG_SELF] && !s_reg.sel);
	assign last_blk = {1'b0, s_reg.blk} + {9'h000, s_reg.cnt}; // R2

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		s_next = s_reg;

		// Register port: read data stand in the cycle after the strobe only.
		s_next.rdata = 32'h0000_0000;
		if (reg_re) begin
			case (reg_addr)
				`RTMSR_REG_CTRL: s_next.rdata = {31'h0000_0000, s_reg.busy};
				`RTMSR_REG_STAT: s_next.rdata = {30'h0000_0000, s_reg.act, s_reg.sel};
				`RTMSR_REG_UIDL: s_next.rdata = s_reg.own[31:0];
				`RTMSR_REG_UIDH: s_next.rdata = s_reg.own[63:32];
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
		if (reg_we) begin
			case (reg_addr)
				`RTMSR_REG_CTRL: s_next.busy = reg_wdata[0];
				`RTMSR_REG_UIDL: s_next.own[31:0] = reg_wdata;
				`RTMSR_REG_UIDH: s_next.own[63:32] = reg_wdata;
				default: s_next.busy = s_reg.busy;
			endcase
		end

		// A byte taken by the front end frees the output; the last one ends the exchange.
		if (s_reg.tx.valid && tx_ready) begin
			s_next.tx.valid = 1'b0;
			if (s_reg.tx.last) begin
				s_next.tx.last = 1'b0;
				s_next.act = 1'b0; // R10 R20 R21
				s_next.st = rtmsr_pkg::ST_IDLE;
			end
		end

		case (s_reg.st)
			rtmsr_pkg::ST_IDLE: begin
				// Activity starts at the start of frame, before the command is known.
				if (rx.sof) begin
					s_next.st = rtmsr_pkg::ST_RECV;
					s_next.act = 1'b1; // R10 R20 R21
					s_next.pos = 5'h00;
					s_next.rcrc = `RTMSR_CRC_INIT;
					s_next.blk = 16'h0000;
					s_next.cnt = 8'h00;
				end
			end
			rtmsr_pkg::ST_RECV: begin
				if (rx.valid) begin
					s_next.rcrc = crc8(s_reg.rcrc, rx.data);
					// Saturate so an overlong frame can never alias a legal length.
					if (s_reg.pos != 5'h1F) begin
						s_next.pos = s_reg.pos + 5'h01;
					end
					if (s_reg.pos == 5'h00) begin
						s_next.flags = rx.data;
					end
					if (s_reg.pos == 5'h01) begin
						s_next.cmd = rx.data;
					end
					// UID arrives least significant byte first.
					if (has_uid && s_reg.pos >= 5'h02 && s_reg.pos < 5'h0A) begin
						s_next.uid = {rx.data, s_reg.uid[63:8]};
					end
					if (s_reg.pos == base) begin
						s_next.blk[7:0] = rx.data; // R1
					end
					if (s_reg.pos == base + 5'h01) begin
						if (ext) begin
							s_next.blk[15:8] = rx.data;
						end else begin
							s_next.cnt = rx.data;
						end
					end
					if (ext && s_reg.pos == base + 5'h02) begin
						s_next.cnt = rx.data;
					end
				end
				if (rx.eof) begin
					s_next.st = rtmsr_pkg::ST_EXEC;
				end
				if (rx.sof) begin
					s_next.pos = 5'h00;
					s_next.rcrc = `RTMSR_CRC_INIT;
				end
			end
			rtmsr_pkg::ST_EXEC: begin
				// Default is a silent drop that releases the pin.
				s_next.st = rtmsr_pkg::ST_IDLE;
				s_next.act = 1'b0;
				s_next.err = 1'b0;
				s_next.ecode = 8'h00;
				s_next.ph = 3'h0;
				s_next.bi = 2'h0;
				s_next.tcrc = `RTMSR_CRC_INIT;
				if (good) begin // R22
					case (s_reg.cmd)
						`RTMSR_CMD_SEL: begin
							if (!match) begin
								s_next.sel = 1'b0; // R14
							end else begin
								s_next.st = rtmsr_pkg::ST_SEND; // R13
								s_next.act = 1'b1;
								if (opt) begin
									// Errors leave the selection as it was.
									s_next.err = 1'b1; // R15
									s_next.ecode = `RTMSR_ERR_OPT; // R16
								end else begin
									s_next.sel = 1'b1; // R13
								end
							end
						end
						`RTMSR_CMD_RDY: begin
							if (reach) begin // R18
								s_next.st = rtmsr_pkg::ST_SEND;
								s_next.act = 1'b1;
								if (opt) begin
									s_next.err = 1'b1;
									s_next.ecode = `RTMSR_ERR_OPT; // R16
								end else begin
									s_next.sel = 1'b0; // R17
								end
							end
						end
						`RTMSR_CMD_READ: begin
							if (reach) begin
								s_next.act = 1'b1;
								s_next.st = rtmsr_pkg::ST_SEND;
								s_next.err = 1'b1;
								if (!ext) begin
									s_next.ecode = `RTMSR_ERR_GEN; // R6
								end else if ({1'b0, s_reg.blk} > `RTMSR_BLK_MAX || last_blk > `RTMSR_BLK_MAX) begin
									s_next.ecode = `RTMSR_ERR_NA; // R3
								end else if (s_reg.cnt >= `RTMSR_MAX_BLKS
									|| s_reg.blk[15:`RTMSR_SEC_LSB] != last_blk[15:`RTMSR_SEC_LSB]) begin
									s_next.ecode = `RTMSR_ERR_GEN; // R4 R5
								end else begin
									s_next.err = 1'b0;
									s_next.st = rtmsr_pkg::ST_FETCH;
								end
							end
						end
						default: s_next.st = rtmsr_pkg::ST_IDLE;
					endcase
				end
			end
			rtmsr_pkg::ST_FETCH: begin
				s_next.st = rtmsr_pkg::ST_LOAD;
			end
			rtmsr_pkg::ST_LOAD: begin
				// All blocks share one sector, so the first block's protection decides.
				s_next.word = mem_rsp.data;
				s_next.secb = {3'b000, mem_rsp.sec[4:0]}; // R8
				s_next.st = rtmsr_pkg::ST_SEND;
				if (s_reg.ph == 3'h0 && mem_rsp.prot) begin
					s_next.err = 1'b1;
					s_next.ecode = `RTMSR_ERR_RP; // R9
				end
			end
			rtmsr_pkg::ST_SEND: begin
				if (!s_next.tx.valid) begin
					s_next.tx.valid = 1'b1;
					case (s_reg.ph)
						3'h0: begin
							s_next.tx.data = s_reg.err ? `RTMSR_RSP_ERR : `RTMSR_RSP_OK;
							if (s_reg.err) begin
								s_next.ph = 3'h1; // R9
							end else if (is_read) begin
								s_next.ph = opt ? 3'h2 : 3'h3; // R7
							end else begin
								s_next.ph = 3'h4; // R19
							end
						end
						3'h1: begin
							s_next.tx.data = s_reg.ecode;
							s_next.ph = 3'h4;
						end
						3'h2: begin
							s_next.tx.data = s_reg.secb; // R7
							s_next.ph = 3'h3;
						end
						3'h3: begin
							s_next.tx.data = s_reg.word[7:0];
							s_next.word = {8'h00, s_reg.word[31:8]};
							s_next.bi = s_reg.bi + 2'h1;
							if (s_reg.bi == 2'h3) begin
								if (s_reg.cnt == 8'h00) begin
									s_next.ph = 3'h4; // R2
								end else begin
									s_next.cnt = s_reg.cnt - 8'h01;
									s_next.blk = s_reg.blk + 16'h0001;
									s_next.ph = opt ? 3'h2 : 3'h3;
									s_next.st = rtmsr_pkg::ST_FETCH;
								end
							end
						end
						3'h4: begin
							s_next.tx.data = ~s_reg.tcrc[7:0]; // R22
							s_next.ph = 3'h5;
						end
						3'h5: begin
							s_next.tx.data = ~s_reg.tcrc[15:8];
							s_next.tx.last = 1'b1;
							s_next.ph = 3'h6;
						end
						default: s_next.tx.valid = 1'b0;
					endcase
					// Every byte ahead of the CRC itself feeds the response CRC.
					if (s_reg.ph < 3'h4) begin
						s_next.tcrc = crc8(s_reg.tcrc, s_next.tx.data); // R22
					end
				end
			end
			default: s_next.st = rtmsr_pkg::ST_IDLE;
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.st <= rtmsr_pkg::ST_IDLE;
			s_reg.rcrc <= `RTMSR_CRC_INIT;
			s_reg.tcrc <= `RTMSR_CRC_INIT;
			s_reg.busy <= `RTMSR_BUSY_RST;
			s_reg.own <= `RTMSR_UID_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The pin is only ever pulled low; write-progress mode never drives it here.
	assign rf_activity_pin_out = 1'b0;
	assign rf_activity_pin_oe = s_reg.busy && s_reg.act; // R10 R11 R20 R21
	assign reg_rdata = s_reg.rdata;
	assign tx = s_reg.tx;
	assign mem_rd = (s_reg.st == rtmsr_pkg::ST_FETCH);
	assign mem_addr = s_reg.blk[8:0]; // R3

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic tx_take;
	assign tx_take = s_reg.tx.valid && tx_ready;

	property p_fetch_range;
		s_reg.st == rtmsr_pkg::ST_FETCH |-> s_reg.blk <= 16'h01FF && s_reg.cnt < `RTMSR_MAX_BLKS;
	endproperty
	a_fetch_range: assert property (p_fetch_range) else $error("Fetch outside block range."); // R3 R4

	property p_ext_err;
		s_reg.st == rtmsr_pkg::ST_EXEC && good && is_read && reach && !ext
			|=> s_reg.err && s_reg.ecode == `RTMSR_ERR_GEN && s_reg.st == rtmsr_pkg::ST_SEND;
	endproperty
	a_ext_err: assert property (p_ext_err) else $error("Missing extension flag not refused."); // R6

	property p_sec_byte;
		s_reg.st == rtmsr_pkg::ST_SEND |-> s_reg.secb[7:5] == 3'b000;
	endproperty
	a_sec_byte: assert property (p_sec_byte) else $error("Security byte reserved bits set."); // R8

	property p_read_code;
		s_reg.st == rtmsr_pkg::ST_SEND && s_reg.ph == 3'h1 && is_read
			|-> s_reg.ecode inside {`RTMSR_ERR_GEN, `RTMSR_ERR_NA, `RTMSR_ERR_RP};
	endproperty
	a_read_code: assert property (p_read_code) else $error("Bad read error code."); // R9

	property p_opt_code;
		s_reg.st == rtmsr_pkg::ST_SEND && s_reg.ph == 3'h1 && !is_read |-> s_reg.ecode == `RTMSR_ERR_OPT;
	endproperty
	a_opt_code: assert property (p_opt_code) else $error("Bad select or ready error code."); // R16

	property p_no_drive;
		!s_reg.busy |-> !rf_activity_pin_oe;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("Pin driven in write-progress mode."); // R11

	property p_pin_low;
		s_reg.st == rtmsr_pkg::ST_IDLE && rx.sof && s_reg.busy && !reg_we
			|=> rf_activity_pin_oe && !rf_activity_pin_out;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("Pin not low after start of frame."); // R10

	property p_pin_release;
		tx_take && s_reg.tx.last |=> !rf_activity_pin_oe && s_reg.st == rtmsr_pkg::ST_IDLE;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("Pin held after response."); // R20 R21

	property p_sel_match;
		s_reg.st == rtmsr_pkg::ST_EXEC && good && s_reg.cmd == `RTMSR_CMD_SEL && match && !opt
			|=> s_reg.sel ##1 s_reg.tx.valid && s_reg.tx.data == `RTMSR_RSP_OK;
	endproperty
	a_sel_match: assert property (p_sel_match) else $error("Matching select not taken."); // R13

	property p_sel_miss;
		s_reg.st == rtmsr_pkg::ST_EXEC && good && s_reg.cmd == `RTMSR_CMD_SEL && !match
			|=> !s_reg.sel && s_reg.st == rtmsr_pkg::ST_IDLE [*2];
	endproperty
	a_sel_miss: assert property (p_sel_miss) else $error("Mismatching select answered."); // R14

	property p_err_keep;
		s_reg.st == rtmsr_pkg::ST_EXEC && good && s_reg.cmd == `RTMSR_CMD_SEL && match && opt
			|=> s_reg.sel == $past(s_reg.sel);
	endproperty
	a_err_keep: assert property (p_err_keep) else $error("Select error changed state."); // R15

	property p_bad_crc;
		s_reg.st == rtmsr_pkg::ST_EXEC && !good |=> s_reg.st == rtmsr_pkg::ST_IDLE && !s_reg.tx.valid;
	endproperty
	a_bad_crc: assert property (p_bad_crc) else $error("Corrupt request answered."); // R22

	c_read_ok: cover property (s_reg.st == rtmsr_pkg::ST_LOAD && !mem_rsp.prot ##1 s_reg.ph == 3'h2);
	c_read_err: cover property (s_reg.st == rtmsr_pkg::ST_SEND && s_reg.ph == 3'h1 && is_read);
	c_select: cover property (s_reg.st == rtmsr_pkg::ST_EXEC && s_reg.cmd == `RTMSR_CMD_SEL && good);
	c_ready: cover property (s_reg.st == rtmsr_pkg::ST_EXEC && s_reg.cmd == `RTMSR_CMD_RDY && good);

endmodule : rtmsr_cmd
`default_nettype wire

// ==== rtl/rtmsr_defs.svh ====
`ifndef RTMSR_DEFS_SVH
`define RTMSR_DEFS_SVH

// ****************************************
// Command codes and request flag bits
// ****************************************
`define RTMSR_CMD_READ 8'h23
`define RTMSR_CMD_SEL 8'h25
`define RTMSR_CMD_RDY 8'h26
`define RTMSR_FLG_EXT 3
`define RTMSR_FLG_SELF 4
`define RTMSR_FLG_ADDR 5
`define RTMSR_FLG_OPT 6

// ****************************************
// Response flags and error codes
// ****************************************
`define RTMSR_RSP_OK 8'h00
`define RTMSR_RSP_ERR 8'h01
`define RTMSR_ERR_OPT 8'h03
`define RTMSR_ERR_GEN 8'h0F
`define RTMSR_ERR_NA 8'h10
`define RTMSR_ERR_RP 8'h15

// ****************************************
// Block space and CRC
// ****************************************
`define RTMSR_BLK_MAX 17'h001FF
`define RTMSR_MAX_BLKS 8'h20
`define RTMSR_SEC_LSB 5
`define RTMSR_CRC_INIT 16'hFFFF
`define RTMSR_CRC_POLY 16'h8408
`define RTMSR_CRC_RES 16'hF0B8

// ****************************************
// Register map and reset values
// ****************************************
`define RTMSR_REG_CTRL 8'h00
`define RTMSR_REG_STAT 8'h04
`define RTMSR_REG_UIDL 8'h08
`define RTMSR_REG_UIDH 8'h0C
`define RTMSR_BUSY_RST 1'b1
`define RTMSR_UID_RST 64'h0000_0000_0000_0000

`endif

// ==== rtl/rtmsr_pkg.sv ====
package rtmsr_pkg;

	// One-hot command handler states.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_EXEC = 6'h04,
		ST_FETCH = 6'h08,
		ST_LOAD = 6'h10,
		ST_SEND = 6'h20
	} rtmsr_st_t;

	// Request byte stream from the RF front end.
	typedef struct packed {
		logic sof;
		logic valid;
		logic eof;
		logic [7:0] data;
	} rtmsr_rx_t;

	// Response byte stream to the RF front end.
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} rtmsr_tx_t;

	// Block read answer from the memory array.
	typedef struct packed {
		logic prot;
		logic [7:0] sec;
		logic [31:0] data;
	} rtmsr_mem_t;

	// Whole state of the command handler.
	typedef struct packed {
		rtmsr_st_t st;
		logic [4:0] pos;
		logic [7:0] flags;
		logic [7:0] cmd;
		logic [63:0] uid;
		logic [15:0] blk;
		logic [7:0] cnt;
		logic [15:0] rcrc;
		logic [15:0] tcrc;
		logic sel;
		logic act;
		logic err;
		logic [7:0] ecode;
		logic [2:0] ph;
		logic [1:0] bi;
		logic [31:0] word;
		logic [7:0] secb;
		rtmsr_tx_t tx;
		logic [31:0] rdata;
		logic busy;
		logic [63:0] own;
	} rtmsr_state_t;

endpackage : rtmsr_pkg

// ==== test/rtmsr_cmd_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtmsr_defs.svh"

module rtmsr_cmd_test;
	typedef struct {logic [111:0] req; int n; logic [87:0] exp; int m; logic sel;} rtmsr_row_t;
	localparam logic [63:0] UIDB = 64'hEFCDAB8967452301;
	localparam logic [63:0] BADB = 64'hEFCDAB8967452300;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [31:0] reg_rdata;
	rtmsr_pkg::rtmsr_rx_t rx;
	rtmsr_pkg::rtmsr_tx_t tx;
	rtmsr_pkg::rtmsr_mem_t mem_rsp = '0;
	logic tx_ready, mem_rd, pin_out, oe, frm;
	logic [8:0] mem_addr;
	logic slow = 1'b0;
	logic mode = 1'b1;
	int err_total = 0;
	int total_checks = 0;
	int oe_bad = 0;
	rtmsr_row_t rows [16];
	logic [31:0] d;
	logic [15:0] c;
	logic [7:0] b;

	rtmsr_cmd u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .rx(rx), .tx_ready(tx_ready), .tx(tx), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rsp(mem_rsp), .rf_activity_pin_out(pin_out), .rf_activity_pin_oe(oe));
	rtmsr_reader u_rdr (.clk(clk), .slow(slow), .rx(rx), .tx(tx), .tx_ready(tx_ready), .frm(frm));

	always #4 clk = ~clk;

	// Memory array: blocks 60h to 7Fh are read protected; idle lines toggle.
	always @(posedge clk) begin
		mem_rsp <= mem_rd ? {mem_addr[8:5] == 4'h3, 8'hFD, 16'hC3A5, 7'h00, mem_addr} : ~mem_rsp;
	end

	// The pin is pulled low through every request frame only in busy mode.
	always @(posedge clk) begin
		if (frm && oe !== mode) oe_bad++;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task wrap_up;
		$display("Checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// A hang is cut short well after the whole sequence should be over.
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rows[0] = '{{8'h00, 8'h25, UIDB}, 10, 8'h00, 1, 1'b1};
		rows[1] = '{{8'h40, 8'h25, UIDB}, 10, 16'h0103, 2, 1'b1};
		rows[2] = '{{8'h00, 8'h25, BADB}, 10, 0, 0, 1'b0};
		rows[3] = '{{8'h00, 8'h25, UIDB}, 10, 8'h00, 1, 1'b1};
		rows[4] = '{{8'h20, 8'h26, BADB}, 10, 0, 0, 1'b1};
		rows[5] = '{{8'h60, 8'h26, UIDB}, 10, 16'h0103, 2, 1'b1};
		rows[6] = '{{8'h20, 8'h26, UIDB}, 10, 8'h00, 1, 1'b0};
		rows[7] = '{32'h0023_0000, 4, 16'h010F, 2, 1'b0};
		rows[8] = '{40'h08_2300_0020, 5, 16'h010F, 2, 1'b0};
		rows[9] = '{40'h08_231F_0001, 5, 16'h010F, 2, 1'b0};
		rows[10] = '{40'h08_2300_0200, 5, 16'h0110, 2, 1'b0};
		rows[11] = '{40'h08_2360_0000, 5, 16'h0115, 2, 1'b0};
		rows[12] = '{40'h48_23FE_0101, 5, {16'h001D, 32'hFE01A5C3, 8'h1D, 32'hFF01A5C3}, 11, 1'b0};
		rows[13] = '{16'h0026, 2, 8'h00, 1, 1'b0};
		// An addressed read carries the UID; a select-flag read while in Ready is ignored.
		rows[14] = '{{8'h28, 8'h23, UIDB, 24'h00_0000}, 13, 40'h00_0000_A5C3, 5, 1'b0};
		rows[15] = '{40'h18_2300_0000, 5, 0, 0, 1'b0};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`RTMSR_REG_CTRL, d);
		chk("ctrl_reset", 32'h1, d);
		rd(8'h10, d);
		chk("unmapped", 32'h0, d);
		wr(`RTMSR_REG_UIDL, 32'h89ABCDEF);
		wr(`RTMSR_REG_UIDH, 32'h01234567);
		rd(`RTMSR_REG_UIDL, d);
		chk("uid_low", 32'h89ABCDEF, d);
		// Each row is one request; the expected bytes get their CRC appended here.
		for (int i = 0; i < 16; i++) begin
			slow <= i[0];
			u_rdr.xfer(rows[i].req, rows[i].n, 1'b0);
			c = `RTMSR_CRC_INIT;
			chk("resp_len", (rows[i].m == 0) ? 0 : rows[i].m + 2, u_rdr.resp.size());
			for (int k = 0; k < rows[i].m; k++) begin
				b = rows[i].exp[8 * (rows[i].m - 1 - k) +: 8];
				c = u_rdr.crc8(c, b);
				if (k < u_rdr.resp.size()) chk("resp_byte", b, u_rdr.resp[k]);
			end
			if (rows[i].m > 0 && u_rdr.resp.size() == rows[i].m + 2) begin
				chk("resp_crc", {16'h0000, ~c}, {u_rdr.resp[rows[i].m + 1], u_rdr.resp[rows[i].m]});
			end
			@(posedge clk);
			#1 chk("pin_release", 32'h0, oe);
			rd(`RTMSR_REG_STAT, d);
			chk("selected", rows[i].sel, d[0]);
		end
		// A request with a spoilt CRC must draw no answer and change nothing.
		u_rdr.xfer({8'h00, 8'h25, UIDB}, 10, 1'b1);
		chk("bad_crc_len", 32'h0, u_rdr.resp.size());
		rd(`RTMSR_REG_STAT, d);
		chk("bad_crc_sel", 32'h0, d[0]);
		// In write-progress mode the pin must never be driven.
		wr(`RTMSR_REG_CTRL, 32'h0);
		mode <= 1'b0;
		u_rdr.xfer({8'h00, 8'h25, UIDB}, 10, 1'b0);
		chk("wip_len", 32'h3, u_rdr.resp.size());
		chk("pin_level", 32'h0, pin_out);
		chk("pin_frames", 32'h0, oe_bad);
		// A reset in mid-run restores busy mode, a zero UID and the Ready state.
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`RTMSR_REG_CTRL, d);
		chk("ctrl_rerst", 32'h1, d);
		rd(`RTMSR_REG_UIDH, d);
		chk("uid_rerst", 32'h0, d);
		rd(`RTMSR_REG_STAT, d);
		chk("stat_rerst", 32'h0, d);
		wrap_up();
	end
endmodule : rtmsr_cmd_test
`default_nettype wire

// ==== test/rtmsr_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtmsr_defs.svh"

// Reader model: sends whole request frames and takes the response bytes.
module rtmsr_reader (
	input wire logic clk,
	input wire logic slow,
	output rtmsr_pkg::rtmsr_rx_t rx,
	input wire rtmsr_pkg::rtmsr_tx_t tx,
	output logic tx_ready,
	output logic frm
);
	logic [7:0] resp [$];

	// One byte of the reflected CRC; the reader appends the inverse, low byte first.
	function automatic logic [15:0] crc8(input logic [15:0] ci, input logic [7:0] b);
		logic [15:0] c;
		c = ci ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `RTMSR_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc8

	// A slow reader takes a byte only every other cycle, so the sender must hold.
	always @(posedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	initial begin
		rx = '0;
		tx_ready = 1'b0;
		frm = 1'b0;
	end

	// Bytes go out back to back; a bad flag spoils the CRC low byte on purpose.
	task automatic xfer(input logic [111:0] q, input int n, input bit bad);
		logic [15:0] c;
		logic [7:0] b;
		int idle;
		resp.delete();
		c = `RTMSR_CRC_INIT;
		b = 8'h00;
		@(posedge clk);
		rx.sof <= 1'b1;
		// The frame window opens one edge after the start pulse, once the handler has seen it.
		@(posedge clk);
		rx.sof <= 1'b0;
		frm <= 1'b1;
		for (int i = 0; i < n + 2; i++) begin
			b = (i < n) ? q[8 * (n - 1 - i) +: 8] : ((i == n) ? (~c[7:0] ^ {7'h00, bad}) : ~c[15:8]);
			if (i < n) c = crc8(c, b);
			rx.valid <= 1'b1;
			rx.data <= b;
			@(posedge clk);
		end
		// The data line is driven with the last byte inverted, so it no longer shows the last byte.
		rx.valid <= 1'b0;
		rx.data <= ~b;
		rx.eof <= 1'b1;
		@(posedge clk);
		rx.eof <= 1'b0;
		frm <= 1'b0;
		idle = 0;
		while (idle < 12) begin
			@(posedge clk);
			idle++;
			if (tx.valid && tx_ready) begin
				resp.push_back(tx.data);
				idle = 0;
				if (tx.last) break;
			end
		end
	endtask : xfer
endmodule : rtmsr_reader
`default_nettype wire
